// [rtl/cis_arbiter.sv]
// lowest-index arbiter over pending and enabled sources
`timescale 1ns/1ps
`default_nettype none
module cis_arbiter
    import cis_pkg::*;
#(
    parameter int N = CIS_NUM_SRC
) (
    // candidates
    input  wire logic [N-1:0]         request,
    // winner
    output logic                      found,
    output logic [CIS_VEC_W-1:0]      index
);
    always_comb begin
        found = 1'b0;
        index = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (request[i]) begin
                found = 1'b1;
                index = CIS_VEC_W'(i + 1);
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/cis_pkg.sv]
// package: constants and carriers for the cpu interrupt sequencer
package cis_pkg;
    localparam int          CIS_NUM_SRC      = 16;
    localparam int          CIS_VEC_W        = 5;
    localparam int          CIS_PC_W         = 16;
    localparam int          CIS_GIE_BIT      = 7;
    localparam logic [4:0]  CIS_RESET_VEC    = 5'h00;
    localparam int          CIS_CLK_MHZ      = 100;
    localparam int          CIS_ENTRY_CYC    = 4;
    localparam int          CIS_JUMP_CYC     = 3;
    localparam int          CIS_WAKE_CYC     = 4;
    localparam int          CIS_RETURN_CYC   = 4;
    localparam int          CIS_PC_PUSH_DEC  = 2;
    localparam int          CIS_PC_POP_INC   = 2;
    localparam logic [7:0]  CIS_FLAG_RESET   = 8'h00;
    localparam logic [3:0]  CIS_CNT_ZERO     = 4'h0;

    // per-cycle instruction report from the fetch/execute pipeline
    typedef struct packed {
        logic boundary;
        logic is_return_from_handler_instr;
        logic is_sei;
        logic is_cli;
        logic sleeping;
    } cis_instr_t;

    // stack and vector request towards the pipeline
    typedef struct packed {
        logic                 push_pc;
        logic                 pop_pc;
        logic                 vector_go;
        logic [CIS_VEC_W-1:0] vector;
    } cis_seq_t;
endpackage

// [rtl/cis_sequencer.sv]
// cpu interrupt sequencer: gating, priority, entry and return timing
// Notes on behaviour
// - fire only if source and global enabled
// - distinct low vectors; lower vector wins
// - reset first, then external line zero
// - accepting an interrupt clears global enable
// - global enable in handler allows nesting
// - return from handler sets global enable
// - vectoring clears latched source flag
// - write one clears flag, zero keeps
// - flag latches even while source disabled
// - pending flags served in priority order
// - level sources request only while present
// - one main instruction after return
// - flag register not saved nor restored
// - disable instruction blocks same-cycle interrupt
// - instruction after enable runs first
// - entry takes four cycles, pushes pc
// - vector jump takes three cycles
// - multi-cycle instruction completes before entry
// - wake from sleep adds four cycles
// - return four cycles, pop, sp plus two
// - global enable is flag bit seven
// - push decrements stack pointer by two
`timescale 1ns/1ps
`default_nettype none
module cis_sequencer
    import cis_pkg::*;
#(
    parameter int        N           = CIS_NUM_SRC,
    parameter logic [N-1:0] LEVEL_MASK = '0
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // peripheral sources
    input  wire logic [N-1:0]      source_event,
    input  wire logic [N-1:0]      source_level,
    input  wire logic [N-1:0]      source_enable,
    input  wire logic [N-1:0]      flag_clear_write,
    // pipeline report
    input  wire cis_instr_t        instr,
    input  wire logic              flag_reg_write,
    input  wire logic [7:0]        flag_reg_wdata,
    input  wire logic [CIS_PC_W-1:0] stack_pointer_in,
    // status
    output logic [N-1:0]           pending_flag,
    output logic                   global_enable,
    output logic [7:0]             cpu_flag_register,
    // pipeline control
    output cis_seq_t               seq,
    output logic                   stall_fetch,
    output logic                   in_handler,
    output logic [CIS_PC_W-1:0]    stack_pointer_out,
    output logic                   stack_pointer_load,
    output logic                   jump_window
);
    typedef enum {
        CIS_IDLE,
        CIS_WAKE,
        CIS_ENTRY,
        CIS_JUMP,
        CIS_RETURN
    } cis_state_t;

    cis_state_t           state;
    logic [3:0]           count;
    logic                 hold_one;
    logic [N-1:0]         flag_latch;
    logic [N-1:0]         request_vec;
    logic                 found;
    logic [CIS_VEC_W-1:0] win_index;
    logic [CIS_VEC_W-1:0] taken_vec;
    logic                 accept;
    logic [7:0]           flag_bits;
    logic [N-1:0]         hw_clear;
    logic                 wake_last;
    logic                 entry_last;
    logic                 jump_last;
    logic                 return_last;
    logic [3:0]           nest_depth;

    // vector index carried by a source position
    function automatic logic [CIS_VEC_W-1:0] source_vector(input int unsigned i);
        source_vector = CIS_VEC_W'(i + 1);
    endfunction

    // last cycle of a counted step
    function automatic logic step_last(
        input cis_state_t now,
        input cis_state_t step,
        input logic [3:0] cnt
    );
        step_last = (now == step) && (cnt == CIS_CNT_ZERO);
    endfunction

    assign wake_last   = step_last(state, CIS_WAKE, count);
    assign entry_last  = step_last(state, CIS_ENTRY, count);
    assign jump_last   = step_last(state, CIS_JUMP, count);
    assign return_last = step_last(state, CIS_RETURN, count);

    assign pending_flag = flag_latch | (source_level & LEVEL_MASK);

    assign request_vec = pending_flag & source_enable & {N{global_enable}};

    cis_arbiter #(.N(N)) u_arbiter (
        .request (request_vec),
        .found   (found),
        .index   (win_index)
    );

    // disable in same cycle blocks accept
    assign accept = (state == CIS_IDLE) && found && instr.boundary
                    && !instr.is_cli && !hold_one;

    // flag set wins over both clears
    for (genvar i = 0; i < N; i++) begin : g_flag
        logic latched;

        assign hw_clear[i]   = accept && (win_index == source_vector(i));
        assign flag_latch[i] = latched;

        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                latched <= 1'b0;
            end else if (LEVEL_MASK[i]) begin
                latched <= 1'b0;
            end else if (source_event[i]) begin
                latched <= 1'b1;
            end else if (flag_clear_write[i]) begin
                latched <= 1'b0;
            end else if (hw_clear[i]) begin
                latched <= 1'b0;
            end
        end
    end

    // only the enable bit is touched by hardware
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flag_bits <= CIS_FLAG_RESET;
        end else if (accept) begin
            flag_bits[CIS_GIE_BIT] <= 1'b0;
        end else if (instr.is_cli) begin
            flag_bits[CIS_GIE_BIT] <= 1'b0;
        end else if (instr.is_sei) begin
            flag_bits[CIS_GIE_BIT] <= 1'b1;
        end else if (state == CIS_RETURN && count == CIS_CNT_ZERO) begin
            flag_bits[CIS_GIE_BIT] <= 1'b1;
        end else if (flag_reg_write) begin
            flag_bits <= flag_reg_wdata;
        end
    end

    assign global_enable     = flag_bits[CIS_GIE_BIT];
    assign cpu_flag_register = flag_bits;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hold_one <= 1'b0;
        end else if (instr.is_sei && !global_enable) begin
            hold_one <= 1'b1;
        end else if (state == CIS_RETURN && count == CIS_CNT_ZERO) begin
            hold_one <= 1'b1;
        end else if (instr.boundary && state == CIS_IDLE) begin
            hold_one <= 1'b0;
        end
    end

    // vector capture at accept
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            taken_vec <= CIS_RESET_VEC;
        end else if (accept) begin
            taken_vec <= win_index;
        end
    end

    // entry, jump and return sequencing
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= CIS_IDLE;
        end else begin
            case (state)
                CIS_IDLE: begin
                    if (accept && instr.sleeping) begin
                        state <= CIS_WAKE;
                    end else if (accept) begin
                        state <= CIS_ENTRY;
                    end else if (instr.is_return_from_handler_instr) begin
                        state <= CIS_RETURN;
                    end
                end
                CIS_WAKE: begin
                    if (wake_last) begin
                        state <= CIS_ENTRY;
                    end
                end
                CIS_ENTRY: begin
                    if (entry_last) begin
                        state <= CIS_JUMP;
                    end
                end
                CIS_JUMP: begin
                    if (jump_last) begin
                        state <= CIS_IDLE;
                    end
                end
                CIS_RETURN: begin
                    if (return_last) begin
                        state <= CIS_IDLE;
                    end
                end
                default: begin
                    state <= CIS_IDLE;
                end
            endcase
        end
    end

    // step counter, reloaded at each step change
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= CIS_CNT_ZERO;
        end else begin
            case (state)
                CIS_IDLE: begin
                    if (accept && instr.sleeping) begin
                        count <= 4'(CIS_WAKE_CYC - 1);
                    end else if (accept) begin
                        count <= 4'(CIS_ENTRY_CYC - 1);
                    end else if (instr.is_return_from_handler_instr) begin
                        count <= 4'(CIS_RETURN_CYC - 1);
                    end
                end
                CIS_WAKE: begin
                    if (wake_last) begin
                        count <= 4'(CIS_ENTRY_CYC - 1);
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                CIS_ENTRY: begin
                    if (entry_last) begin
                        count <= 4'(CIS_JUMP_CYC - 1);
                    end else begin
                        count <= count - 4'h1;
                    end
                end
                CIS_JUMP, CIS_RETURN: begin
                    if (!jump_last && !return_last) begin
                        count <= count - 4'h1;
                    end
                end
                default: begin
                    count <= CIS_CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            nest_depth <= CIS_CNT_ZERO;
        end else if (entry_last) begin
            nest_depth <= nest_depth + 4'h1;
        end else if (return_last && nest_depth != CIS_CNT_ZERO) begin
            nest_depth <= nest_depth - 4'h1;
        end
    end

    // handler status held until outermost return
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            in_handler <= 1'b0;
        end else if (entry_last) begin
            in_handler <= 1'b1;
        end else if (return_last && nest_depth <= 4'h1) begin
            in_handler <= 1'b0;
        end
    end

    // stack pointer outputs, registered
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stack_pointer_out  <= '0;
            stack_pointer_load <= 1'b0;
        end else if (state == CIS_ENTRY && count == CIS_CNT_ZERO) begin
            stack_pointer_out  <= stack_pointer_in - CIS_PC_W'(CIS_PC_PUSH_DEC);
            stack_pointer_load <= 1'b1;
        end else if (state == CIS_RETURN && count == CIS_CNT_ZERO) begin
            stack_pointer_out  <= stack_pointer_in + CIS_PC_W'(CIS_PC_POP_INC);
            stack_pointer_load <= 1'b1;
        end else begin
            stack_pointer_load <= 1'b0;
        end
    end

    assign seq.push_pc   = (state == CIS_ENTRY);
    assign seq.pop_pc    = (state == CIS_RETURN);
    assign seq.vector_go = (state == CIS_ENTRY) && (count == CIS_CNT_ZERO);
    assign seq.vector    = taken_vec;
    assign stall_fetch   = (state != CIS_IDLE);
    assign jump_window   = (state == CIS_JUMP);
endmodule
`default_nettype wire

// [tb/cis_pipe_model.sv]
// pipeline model: instruction report and stack pointer
`timescale 1ns/1ps
`default_nettype none
module cis_pipe_model
    import cis_pkg::*;
#(
    parameter logic [CIS_PC_W-1:0] SP_INIT = 16'h0200
) (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                reset_n,
    // bench command: 1 enable, 2 disable, 3 return
    input wire logic [1:0]          op,
    input wire logic                busy,
    input wire logic                sleep,
    // sequencer side
    input wire logic                stall_fetch,
    input wire logic [CIS_PC_W-1:0] stack_pointer_out,
    input wire logic                stack_pointer_load,
    output cis_instr_t              instr,
    output logic [CIS_PC_W-1:0]     sp
);
    // no boundary while stalled or inside a multi-cycle instruction
    assign instr = {!stall_fetch && !busy, op == 2'h3, op == 2'h1, op == 2'h2, sleep};
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sp <= SP_INIT;
        end else if (stack_pointer_load) begin
            sp <= stack_pointer_out;
        end
    end
endmodule
`default_nettype wire

// [tb/cis_seq_sva.sv]
// assertion checker for the interrupt sequencer ports
`timescale 1ns/1ps
`default_nettype none
module cis_seq_sva
    import cis_pkg::*;
#(
    parameter int N = CIS_NUM_SRC
) (
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                reset_n,
    // watched ports
    input wire logic [N-1:0]        source_enable,
    input wire logic [N-1:0]        pending_flag,
    input wire cis_instr_t          instr,
    input wire logic                global_enable,
    input wire logic [7:0]          cpu_flag_register,
    input wire cis_seq_t            seq,
    input wire logic [CIS_PC_W-1:0] stack_pointer_in,
    input wire logic [CIS_PC_W-1:0] stack_pointer_out,
    input wire logic                stack_pointer_load,
    input wire logic                jump_window
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_entry;
        seq.push_pc[*3] ##1 (seq.push_pc && seq.vector_go) ##1 !seq.push_pc;
    endsequence
    sequence s_return;
        seq.pop_pc[*4] ##1 (global_enable && stack_pointer_load);
    endsequence
    chk_gie_bit: assert property (
        global_enable == cpu_flag_register[CIS_GIE_BIT]) else $error("enable not flag bit");
    chk_entry_len: assert property (
        $rose(seq.push_pc) |-> s_entry) else $error("entry length wrong");
    chk_entry_gate: assert property (
        $rose(seq.push_pc) && !instr.sleeping |-> !global_enable && $past(global_enable)
        && $past(|(pending_flag & source_enable))) else $error("entry without cause");
    chk_jump_three: assert property (
        seq.vector_go |=> jump_window[*3] ##1 !jump_window) else $error("jump length wrong");
    chk_push_sp: assert property (
        seq.vector_go |=> stack_pointer_load
        && stack_pointer_out == $past(stack_pointer_in) - 16'h2) else $error("push sp wrong");
    chk_ret_four: assert property (
        $rose(seq.pop_pc) |-> s_return) else $error("return length wrong");
    chk_pop_sp: assert property (
        $fell(seq.pop_pc) |-> stack_pointer_out == $past(stack_pointer_in) + 16'h2)
        else $error("pop sp wrong");
    chk_one_after: assert property (
        $fell(seq.pop_pc) |-> !seq.push_pc[*2]) else $error("no instruction after return");
    chk_sei_delay: assert property (
        instr.boundary && instr.is_sei && !global_enable |=> !seq.push_pc[*2])
        else $error("entry right after enable");
    chk_cli_block: assert property (
        instr.boundary && instr.is_cli |=> !seq.push_pc && !global_enable)
        else $error("entry after disable");
endmodule
bind cis_sequencer cis_seq_sva #(.N(N)) u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
    .source_enable(source_enable), .pending_flag(pending_flag), .instr(instr),
    .global_enable(global_enable), .cpu_flag_register(cpu_flag_register), .seq(seq),
    .stack_pointer_in(stack_pointer_in), .stack_pointer_out(stack_pointer_out),
    .stack_pointer_load(stack_pointer_load), .jump_window(jump_window));
`default_nettype wire

// [tb/tb_cpu_interrupt_sequencer.sv]
// testbench for the interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_sequencer
    import cis_pkg::*;
;
    logic clk_sys = 0, reset_n = 0, busy = 0, sleep = 0, frw = 0;
    logic [15:0] source_event = '0, source_level = '0, source_enable = '0, fcw = '0;
    logic [15:0] pending_flag, sp_in, sp_out;
    logic [1:0] op = '0;
    logic [7:0] fwd = '0, cpu_flag_register;
    logic global_enable, stall_fetch, in_handler, sp_load, jump_window;
    cis_instr_t instr;
    cis_seq_t seq;
    int n_errors = 0, n_compared = 0, n0, n1;
    always #5 clk_sys = ~clk_sys;
    cis_pipe_model PIPE (.clk_sys(clk_sys), .reset_n(reset_n), .op(op), .busy(busy),
        .sleep(sleep), .stall_fetch(stall_fetch), .stack_pointer_out(sp_out),
        .stack_pointer_load(sp_load), .instr(instr), .sp(sp_in));
    cis_sequencer #(.LEVEL_MASK(16'h8000)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .source_event(source_event), .source_level(source_level),
        .source_enable(source_enable), .flag_clear_write(fcw), .instr(instr),
        .flag_reg_write(frw), .flag_reg_wdata(fwd), .stack_pointer_in(sp_in),
        .pending_flag(pending_flag), .global_enable(global_enable),
        .cpu_flag_register(cpu_flag_register), .seq(seq), .stall_fetch(stall_fetch),
        .in_handler(in_handler), .stack_pointer_out(sp_out),
        .stack_pointer_load(sp_load), .jump_window(jump_window));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic do_op(input logic [1:0] o);
        op = o;
        cyc(1);
        op = 2'h0;
    endtask
    task automatic pulse(input logic [15:0] e);
        source_event = e;
        cyc(1);
        source_event = '0;
    endtask
    task automatic to_vec(output int n);
        n = 0;
        while (seq.vector_go !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic ret();
        cyc(4);
        do_op(2'h3);
        cyc(7);
    endtask
    task automatic t_latch();
        do_op(2'h1);
        pulse(16'h0008);
        cyc(12);
        check("idle", in_handler, 1'b0);
        check("latched", pending_flag, 16'h0008);
        fcw = 16'h0004;
        cyc(1);
        check("kept", pending_flag, 16'h0008);
        fcw = 16'h0008;
        cyc(1);
        fcw = '0;
        check("cleared", pending_flag, 16'h0000);
        do_op(2'h2);
    endtask
    task automatic t_prio();
        source_enable = 16'h0021;
        pulse(16'h0021);
        cyc(10);
        check("held", in_handler, 1'b0);
        do_op(2'h1);
        to_vec(n0);
        check("first vec", seq.vector, 5'h01);
        check("gie off", global_enable, 1'b0);
        cyc(1);
        check("hw clear", pending_flag, 16'h0020);
        cyc(4);
        do_op(2'h1);
        to_vec(n0);
        check("nested vec", seq.vector, 5'h06);
        check("nested in", in_handler, 1'b1);
        ret();
        check("nest kept", in_handler, 1'b1);
        ret();
        check("gie back", global_enable, 1'b1);
        check("nest done", in_handler, 1'b0);
    endtask
    task automatic t_cli_multi();
        source_enable = 16'h0002;
        busy = 1;
        pulse(16'h0002);
        busy = 0;
        do_op(2'h2);
        cyc(12);
        check("cli blocks", in_handler, 1'b0);
        check("cli pending", pending_flag, 16'h0002);
        do_op(2'h1);
        busy = 1;
        cyc(10);
        check("multi held", in_handler, 1'b0);
        busy = 0;
        to_vec(n0);
        check("multi vec", seq.vector, 5'h02);
        ret();
    endtask
    task automatic t_sleep();
        source_enable = 16'h0010;
        pulse(16'h0010);
        to_vec(n0);
        ret();
        sleep = 1;
        pulse(16'h0010);
        to_vec(n1);
        sleep = 0;
        check("wake extra", 16'(n1 - n0), 16'(CIS_WAKE_CYC));
        ret();
    endtask
    task automatic t_level();
        do_op(2'h2);
        source_enable = '0;
        source_level = 16'h8000;
        cyc(2);
        source_level = '0;
        source_enable = 16'h8000;
        frw = 1;
        fwd = 8'h95;
        cyc(1);
        frw = 0;
        cyc(12);
        check("gone level", in_handler, 1'b0);
        source_level = 16'h8000;
        to_vec(n0);
        source_level = '0;
        check("level vec", seq.vector, 5'h10);
        check("flags kept", cpu_flag_register, 8'h15);
        ret();
        check("flags back", cpu_flag_register, 8'h95);
    endtask
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        close_out();
    end
    initial begin
        cyc(5);
        reset_n = 1;
        check("reset flags", cpu_flag_register, CIS_FLAG_RESET);
        t_latch();
        t_prio();
        t_cli_multi();
        t_sleep();
        t_level();
        close_out();
    end
endmodule
`default_nettype wire
